/* sacc_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sacc_analog_model
	import sacc_pkg::*;
(
	input  wire sacc_analog_t analog,
	input  wire logic [31:0]  levels,
	output logic              comparator_high
);
	logic [7:0] held_r;

	// The hold capacitor keeps the level seen while sampling, so a late channel change cannot leak in.
	always_latch begin
		if (analog.sample_hold)
			held_r <= levels[8*analog.channel +: 8];
	end

	// An unpowered converter gives no useful comparison.
	assign comparator_high = analog.powered ? (held_r >= analog.dac_code) : 1'h1;
endmodule
`default_nettype wire

/* sacc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module sacc_checker
	import sacc_pkg::*;
(
	input wire logic         mclk,
	input wire logic         rst_b,
	input wire logic         s_axi_awvalid,
	input wire logic         s_axi_awready,
	input wire logic         s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	input wire sacc_analog_t analog
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////////
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after take");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data not one cycle after take");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed before taken");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");

	////////////////////////////////////////////////////////////////////////////////
	a_off_idle: assert property (!analog.powered [*2] |-> !analog.sample_hold)
		else $error("sampling while converter off");
	a_chan_locked: assert property (analog.sample_hold [*2] |-> $stable(analog.channel))
		else $error("channel moved during conversion");
	a_chan_needs_en: assert property (!analog.powered [*2] |-> $stable(analog.channel))
		else $error("channel moved while converter off");
endmodule

bind sacc_top sacc_checker chk_u (
	.mclk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .analog
);
`default_nettype wire

/* sacc_pkg.sv */
`default_nettype none
package sacc_pkg;
	localparam int        ADDR_W         = 5;
	localparam logic [4:0] CTRL_A_OFS    = 5'h00;
	localparam logic [4:0] CTRL_B_OFS    = 5'h04;
	localparam logic [4:0] CHAN_OFS      = 5'h08;
	localparam logic [4:0] RESULT_OFS    = 5'h0C;
	localparam logic [4:0] POWER_OFS     = 5'h10;
	localparam int        EN_BIT         = 7;
	localparam int        START_BIT      = 6;
	localparam int        AUTO_BIT       = 5;
	localparam int        DONE_BIT       = 4;
	localparam int        IEN_BIT        = 3;
	localparam int        DIV_LSB        = 0;
	localparam int        TSEL_LSB       = 0;
	localparam int        CHAN_LSB       = 0;
	localparam int        PGATE_BIT      = 0;
	localparam logic [2:0] DIV_RST       = 3'h0;
	localparam logic [2:0] TSEL_RST      = 3'h0;
	localparam logic [2:0] TSEL_SELF     = 3'h0;
	localparam logic [1:0] CHAN_RST      = 2'h0;
	localparam logic [7:0] RESULT_RST    = 8'h00;
	localparam logic [4:0] NORMAL_LEN    = 5'd13;
	localparam logic [4:0] FIRST_LEN     = 5'd25;
	localparam logic [4:0] SAR_LEAD      = 5'd9;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;

	typedef enum logic [1:0] {
		SACC_IDLE = 2'b00,
		SACC_ARM  = 2'b01,
		SACC_CONV = 2'b11
	} sacc_state_t;

	typedef struct packed {
		logic       enable;
		logic       start;
		logic       auto_trig;
		logic       done;
		logic       int_en;
		logic [2:0] div_sel;
	} sacc_ctrl_t;

	typedef struct packed {
		logic       powered;
		logic       sample_hold;
		logic [1:0] channel;
		logic [7:0] dac_code;
	} sacc_analog_t;
endpackage
`default_nettype wire

/* sacc_top.sv */
// Notes on behaviour
// [RL1] Converter runs only while enable bit set.
// [RL2] Channel choice waits for enable bit.
// [RL3] Successive approximation yields 8-bit unsigned code.
// [RL4] Channel field picks one of four inputs.
// [RL5] Completed result lands in result register.
// [RL6] Completion raises the converter interrupt request.
// [RL7] Writing one to start begins a conversion.
// [RL8] Start bit holds, hardware clears at finish.
// [RL9] Channel change waits until conversion finishes.
// [RL10] Auto-trigger starts from selected internal source.
// [RL11] Trigger rising edge resets prescaler, starts conversion.
// [RL12] Still-high trigger starts nothing; needs new edge.
// [RL13] Edges during a conversion are dropped.
// [RL14] Software clears trigger flags before next event.
// [RL15] Self-trigger restarts each finish; first manual.
// [RL16] Manual start still works under auto-trigger.
// [RL17] Start bit reads one whenever converting.
// [RL18] Software keeps converter clock within range.
// [RL19] Prescaler runs only while enabled, else reset.
// [RL20] Software clears power gate before use.
// [RL21] Divide select gives power-of-two ratios.
// [RL22] Conversions take 13 cycles, first 25.
// [RL23] Result, done flag, start clear together.
// [RL24] Manual start begins at next converter clock.
`timescale 1ns/100ps
`default_nettype none
module sacc_top
	import sacc_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst_b,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic [7:0]         trigger_sources,
	input  wire logic               comparator_high,
	output sacc_analog_t            analog,
	output logic                    converter_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic              aw_have_r, aw_have_nxt;
	logic [31:0]       w_data_r, w_data_nxt;
	logic              w_lo_r, w_lo_nxt;
	logic              w_have_r, w_have_nxt;
	logic              awready_r, awready_nxt, wready_r, wready_nxt;
	logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt;
	logic              rvalid_r, rvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic              wr_go;
	logic [31:0]       rd_word;
	logic              rd_hit, wr_hit;

	sacc_ctrl_t  ctrl_r, ctrl_nxt;
	logic [2:0]  tsel_r, tsel_nxt;
	logic [1:0]  chan_sel_r, chan_sel_nxt;
	logic [7:0]  result_r, result_nxt;
	logic        pgate_r, pgate_nxt;
	sacc_state_t state_r, state_nxt;

	always_comb begin
		wr_go   = aw_have_r && w_have_r && !bvalid_r;
		wr_hit  = (aw_addr_r == CTRL_A_OFS) || (aw_addr_r == CTRL_B_OFS) ||
			(aw_addr_r == CHAN_OFS) || (aw_addr_r == RESULT_OFS) ||
			(aw_addr_r == POWER_OFS);
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			CTRL_A_OFS: begin
				rd_word[EN_BIT]                = ctrl_r.enable;
				rd_word[START_BIT]             = ctrl_r.start || state_r != SACC_IDLE; // see [RL17]
				rd_word[AUTO_BIT]              = ctrl_r.auto_trig;
				rd_word[DONE_BIT]              = ctrl_r.done;
				rd_word[IEN_BIT]               = ctrl_r.int_en;
				rd_word[DIV_LSB +: 3]          = ctrl_r.div_sel;
			end
			CTRL_B_OFS: rd_word[TSEL_LSB +: 3] = tsel_r;
			CHAN_OFS:   rd_word[CHAN_LSB +: 2] = chan_sel_r;
			RESULT_OFS: rd_word[7:0]           = result_r; // see [RL5]
			POWER_OFS:  rd_word[PGATE_BIT]     = pgate_r;
			default:    rd_hit                 = 1'b0;
		endcase

		aw_addr_nxt = aw_addr_r;
		aw_have_nxt = aw_have_r;
		w_data_nxt  = w_data_r;
		w_lo_nxt    = w_lo_r;
		w_have_nxt  = w_have_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		arready_nxt = 1'b0;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (s_axi_awvalid && awready_r) begin
			aw_addr_nxt = s_axi_awaddr;
			aw_have_nxt = 1'b1;
		end
		if (s_axi_wvalid && wready_r) begin
			w_data_nxt  = s_axi_wdata;
			w_lo_nxt    = s_axi_wstrb[0];
			w_have_nxt  = 1'b1;
		end
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt  = 1'b0;
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt  = 1'b1;
			rdata_nxt   = rd_word;
			rresp_nxt   = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt  = 1'b0;
		end
		arready_nxt = !rvalid_nxt && !arready_r && !(s_axi_arvalid && arready_r);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aw_addr_r <= '0;
			aw_have_r <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_lo_r    <= 1'b0;
			w_have_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
		end else begin
			aw_addr_r <= aw_addr_nxt;
			aw_have_r <= aw_have_nxt;
			w_data_r  <= w_data_nxt;
			w_lo_r    <= w_lo_nxt;
			w_have_r  <= w_have_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparator pin synchroniser; a change counts once stages two and three agree.

	logic cmp_s1_r, cmp_s2_r, cmp_s3_r, cmp_val_r, cmp_val_nxt;

	always_comb begin
		cmp_val_nxt = (cmp_s2_r == cmp_s3_r) ? cmp_s3_r : cmp_val_r;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cmp_s1_r  <= 1'b0;
			cmp_s2_r  <= 1'b0;
			cmp_s3_r  <= 1'b0;
			cmp_val_r <= 1'b0;
		end else begin
			cmp_s1_r  <= comparator_high;
			cmp_s2_r  <= cmp_s1_r;
			cmp_s3_r  <= cmp_s2_r;
			cmp_val_r <= cmp_val_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler, trigger and conversion sequencer.

	logic [7:0]  pre_cnt_r, pre_cnt_nxt;
	logic        trig_prev_r, trig_prev_nxt;
	logic        first_r, first_nxt;
	logic [4:0]  cyc_r, cyc_nxt;
	logic [3:0]  bit_idx_r, bit_idx_nxt;
	logic [1:0]  act_ch_r, act_ch_nxt;
	logic        irq_r, irq_nxt;
	sacc_analog_t ana_r, ana_nxt;
	logic        on, tick, trig_sel, trig_rise, man_start, finish;
	logic [7:0]  pre_top;
	logic [4:0]  conv_len, cyc_inc;

	always_comb begin
		on        = ctrl_r.enable && !pgate_r; // see [RL1]
		pre_top   = 8'((9'd2 << ctrl_r.div_sel) - 9'd1); // see [RL21]
		tick      = pre_cnt_r == pre_top;
		trig_sel  = trigger_sources[tsel_r];
		trig_rise = trig_sel && !trig_prev_r; // see [RL12]
		conv_len  = first_r ? FIRST_LEN : NORMAL_LEN; // see [RL22]
		cyc_inc   = cyc_r + 5'd1;
		finish    = state_r == SACC_CONV && tick && cyc_inc == conv_len;
		man_start = wr_go && aw_addr_r == CTRL_A_OFS && w_lo_r &&
			w_data_r[START_BIT] && w_data_r[EN_BIT]; // see [RL7] [RL16]

		ctrl_nxt      = ctrl_r;
		tsel_nxt      = tsel_r;
		chan_sel_nxt  = chan_sel_r;
		pgate_nxt     = pgate_r;
		result_nxt    = result_r;
		state_nxt     = state_r;
		first_nxt     = first_r;
		cyc_nxt       = cyc_r;
		bit_idx_nxt   = bit_idx_r;
		act_ch_nxt    = act_ch_r;
		ana_nxt       = ana_r;
		trig_prev_nxt = trig_sel;
		pre_cnt_nxt   = tick ? 8'h00 : pre_cnt_r + 8'h01;

		if (wr_go && w_lo_r) begin
			case (aw_addr_r)
				CTRL_A_OFS: begin
					ctrl_nxt.enable    = w_data_r[EN_BIT];
					ctrl_nxt.auto_trig = w_data_r[AUTO_BIT];
					ctrl_nxt.int_en    = w_data_r[IEN_BIT];
					ctrl_nxt.div_sel   = w_data_r[DIV_LSB +: 3];
					if (w_data_r[DONE_BIT])
						ctrl_nxt.done = 1'b0;
					if (man_start)
						ctrl_nxt.start = 1'b1;
				end
				CTRL_B_OFS: tsel_nxt     = w_data_r[TSEL_LSB +: 3];
				CHAN_OFS:   chan_sel_nxt = w_data_r[CHAN_LSB +: 2];
				POWER_OFS:  pgate_nxt    = w_data_r[PGATE_BIT];
				default:    pgate_nxt    = pgate_r;
			endcase
		end

		case (state_r)
			SACC_IDLE: begin
				// Only an idle converter listens, so edges during a run are not queued.
				if (ctrl_r.auto_trig && trig_rise && tsel_r != TSEL_SELF) begin
					pre_cnt_nxt    = 8'h00; // see [RL10] [RL11] [RL13]
					ctrl_nxt.start = 1'b1;
					state_nxt      = SACC_CONV;
					cyc_nxt        = 5'd0;
				end else if (ctrl_r.start) begin
					state_nxt      = SACC_ARM;
				end
			end
			SACC_ARM: begin
				if (tick) begin
					state_nxt = SACC_CONV; // see [RL24]
					cyc_nxt   = 5'd0;
				end
			end
			SACC_CONV: begin
				if (tick) begin
					cyc_nxt = cyc_inc;
					if (cyc_inc == conv_len - SAR_LEAD) begin
						ana_nxt.sample_hold = 1'b0;
						ana_nxt.dac_code    = 8'h80; // see [RL3]
						bit_idx_nxt         = 4'd7;
					end else if (bit_idx_r != 4'hF) begin
						if (!cmp_val_r)
							ana_nxt.dac_code[bit_idx_r[2:0]] = 1'b0;
						if (bit_idx_r != 4'd0)
							ana_nxt.dac_code[bit_idx_r[2:0] - 3'd1] = 1'b1;
						bit_idx_nxt = bit_idx_r - 4'd1;
					end
				end
				if (finish) begin
					result_nxt     = ana_r.dac_code; // see [RL5] [RL23]
					first_nxt      = 1'b0;
					// Self-triggered mode restarts at once, whatever the done flag holds.
					if (ctrl_r.auto_trig && tsel_r == TSEL_SELF) begin
						cyc_nxt   = 5'd0; // see [RL15]
					end else begin
						ctrl_nxt.start = 1'b0; // see [RL8] [RL23]
						state_nxt      = SACC_IDLE;
					end
				end
			end
			default: state_nxt = SACC_IDLE;
		endcase

		if (finish)
			ctrl_nxt.done = 1'b1; // see [RL23]

		if (state_nxt == SACC_CONV && (state_r != SACC_CONV || finish)) begin
			ana_nxt.sample_hold = 1'b1;
			bit_idx_nxt         = 4'hF;
		end
		// Channel latch follows the field only between conversions.
		if (state_nxt != SACC_CONV || finish)
			act_ch_nxt = chan_sel_nxt; // see [RL4] [RL9]
		if (state_r == SACC_IDLE && state_nxt == SACC_CONV)
			act_ch_nxt = chan_sel_r;

		if (!on) begin
			pre_cnt_nxt    = 8'h00; // see [RL19]
			state_nxt      = SACC_IDLE;
			ctrl_nxt.start = 1'b0;
			first_nxt      = 1'b1;
			ana_nxt.sample_hold = 1'b0;
		end
		ana_nxt.powered = on;
		ana_nxt.channel = on ? act_ch_nxt : ana_r.channel; // see [RL2]
		irq_nxt = ctrl_nxt.done && ctrl_nxt.int_en; // see [RL6]
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r      <= '{enable: 1'b0, start: 1'b0, auto_trig: 1'b0, done: 1'b0,
				int_en: 1'b0, div_sel: DIV_RST};
			tsel_r      <= TSEL_RST;
			chan_sel_r  <= CHAN_RST;
			pgate_r     <= 1'b0;
			result_r    <= RESULT_RST;
			state_r     <= SACC_IDLE;
			first_r     <= 1'b1;
			cyc_r       <= 5'd0;
			bit_idx_r   <= 4'hF;
			act_ch_r    <= CHAN_RST;
			ana_r       <= '0;
			pre_cnt_r   <= 8'h00;
			trig_prev_r <= 1'b0;
			irq_r       <= 1'b0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			tsel_r      <= tsel_nxt;
			chan_sel_r  <= chan_sel_nxt;
			pgate_r     <= pgate_nxt;
			result_r    <= result_nxt;
			state_r     <= state_nxt;
			first_r     <= first_nxt;
			cyc_r       <= cyc_nxt;
			bit_idx_r   <= bit_idx_nxt;
			act_ch_r    <= act_ch_nxt;
			ana_r       <= ana_nxt;
			pre_cnt_r   <= pre_cnt_nxt;
			trig_prev_r <= trig_prev_nxt;
			irq_r       <= irq_nxt;
		end
	end

	// The comparator path lags about four mclk cycles, so a bit decided on
	// one converter tick reflects the trial set on the previous tick when div_sel is 2 or more.
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign analog        = ana_r;
	assign converter_irq = irq_r;

endmodule
`default_nettype wire

/* sacc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sacc_top_tb
	import sacc_pkg::*;
;
	localparam logic [7:0]  EN  = 8'h80;
	localparam logic [7:0]  ST  = 8'h40;
	localparam logic [7:0]  AT  = 8'h20;
	localparam logic [7:0]  DN  = 8'h10;
	localparam logic [7:0]  IE  = 8'h08;
	localparam logic [31:0] LVL = 32'h3CA5FF00;
	logic              mclk;
	logic              rst_b;
	logic [ADDR_W-1:0] s_axi_awaddr;
	logic              s_axi_awvalid;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata;
	logic [3:0]        s_axi_wstrb;
	logic              s_axi_wvalid;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready;
	logic [ADDR_W-1:0] s_axi_araddr;
	logic              s_axi_arvalid;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready;
	logic [7:0]        trigger_sources;
	logic              comparator_high;
	sacc_analog_t      analog;
	logic              converter_irq;
	int                n_mismatch;
	int                cmp_count;
	int                cycles;
	int                starts;

	sacc_top dut_u (
		.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_sources, .comparator_high,
		.analog, .converter_irq
	);
	sacc_analog_model mdl_u (.analog, .levels(LVL), .comparator_high);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'((a > POWER_OFS) ? RESP_SLVERR : RESP_OKAY));
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata & {24'h0, m}, {24'h0, e});
		chk(32'(s_axi_rresp), 32'((a > POWER_OFS) ? RESP_SLVERR : RESP_OKAY));
	endtask

	task automatic wait_irq(input int lo, input int hi);
		int n;
		n = 0;
		while (converter_irq !== 1'h1) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask

	task automatic complete_run();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge analog.sample_hold) starts++;

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		{rst_b, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, trigger_sources} = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'h1;
		{n_mismatch, cmp_count, cycles, starts} = '0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'h1;
		repeat (2) @(posedge mclk);
		rd(CTRL_A_OFS, 8'hFF, 8'h00);
		rd(RESULT_OFS, 8'hFF, RESULT_RST);
		rd(5'h14, 8'hFF, 8'h00);
		wr(5'h14, 8'hFF);
		wr(CHAN_OFS, 8'h02);
		repeat (2) @(posedge mclk);
		chk(32'(analog.channel), 32'h0);
		wr(CTRL_A_OFS, EN | IE | 8'h02);
		wr(CTRL_A_OFS, EN | ST | IE | 8'h02);
		wait_irq(190, 212);
		rd(RESULT_OFS, 8'hFF, 8'hA5);
		// Each channel in turn, with a channel write landing mid-conversion.
		for (int c = 0; c < 4; c++) begin
			wr(CTRL_A_OFS, EN | DN | IE | 8'h03);
			@(posedge mclk);
			chk(32'(converter_irq), 32'h0);
			wr(CHAN_OFS, 8'(c));
			wr(CTRL_A_OFS, EN | ST | IE | 8'h03);
			repeat (16) @(posedge mclk);
			wr(CHAN_OFS, 8'(3 - c));
			chk(32'(analog.channel), 32'(c));
			rd(CTRL_A_OFS, ST, ST);
			wait_irq(150, 232);
			rd(RESULT_OFS, 8'hFF, LVL[8*c +: 8]);
			rd(CTRL_A_OFS, ST | DN, DN);
		end
		wr(CTRL_A_OFS, EN | DN | IE);
		wr(CTRL_B_OFS, 8'h03);
		wr(CTRL_A_OFS, EN | AT | IE);
		starts = 0;
		trigger_sources <= 8'h20;
		repeat (40) @(posedge mclk);
		chk(starts, 0);
		trigger_sources <= 8'h28;
		repeat (8) @(posedge mclk);
		trigger_sources <= 8'h20;
		@(posedge mclk);
		trigger_sources <= 8'h28;
		wait_irq(0, 40);
		wr(CTRL_A_OFS, EN | AT | DN | IE);
		repeat (60) @(posedge mclk);
		chk(starts, 1);
		rd(CTRL_A_OFS, ST | DN, 8'h00);
		wr(CTRL_A_OFS, EN | AT | ST | IE);
		wait_irq(20, 36);
		chk(starts, 2);
		trigger_sources <= 8'h00;
		wr(CTRL_B_OFS, {5'h0, TSEL_SELF});
		wr(CTRL_A_OFS, EN | AT | DN | IE);
		starts = 0;
		repeat (60) @(posedge mclk);
		chk(starts, 0);
		wr(CTRL_A_OFS, EN | AT | ST);
		repeat (100) @(posedge mclk);
		chk(32'(starts >= 3), 32'h1);
		rd(CTRL_A_OFS, ST, ST);
		wr(CTRL_A_OFS, 8'h00);
		starts = 0;
		repeat (60) @(posedge mclk);
		chk(starts, 0);
		rd(CTRL_A_OFS, ST, 8'h00);
		wr(POWER_OFS, 8'h01);
		wr(CTRL_A_OFS, EN | ST);
		rd(POWER_OFS, 8'hFF, 8'h01);
		chk(32'(analog.powered), 32'h0);
		repeat (60) @(posedge mclk);
		chk(starts, 0);
		complete_run();
	end
endmodule
`default_nettype wire
